// File: design/mft_pkg.sv
// constants and register map of the multi-function timer
// Functional notes
// - one 8-bit control/status register: flags 7:6, enables 5:4, acks 3:2, select 1:0.
// - overflow flag sets when the 8-bit ripple count wraps to zero.
// - overflow flag with its enable set raises the timer request.
// - writing one to overflow acknowledge clears the flag; zero leaves it.
// - direct writes to either flag bit are ignored.
// - periodic tick flag sets when the selected divider stage goes active.
// - tick flag with its enable set raises the timer request.
// - writing one to tick acknowledge clears the tick flag; zero leaves it.
// - acknowledge bits are write-only, read as zero, hold no state.
// - reset clears flags and enables, sets both period select bits.
// - tick period is bus clock divided by 2^14, 2^15, 2^16 or 2^17.
// - leaving stop waits 128 or 4064 cycles of stabilization before running.
// - 8-bit ripple count runs at bus rate over four, readable anytime.
// - overflow events occur at bus rate divided by 1024.
// - tick selector fed at bus rate over 16384 plus three halving stages.
// - reset clears the whole chain; counting restarts from zero.
package mft_pkg;
    // avalon byte addresses
    localparam int          ADDR_W      = 5;
    localparam logic [4:0]  ADDR_TCS    = 5'h08;
    localparam logic [4:0]  ADDR_COUNT  = 5'h0c;
    localparam logic [4:0]  ADDR_ISTAT  = 5'h10;
    localparam logic [4:0]  ADDR_IMASK  = 5'h14;
    localparam logic [4:0]  ADDR_STAB   = 5'h18;
    // control/status field positions
    localparam int          BIT_OVF     = 7;
    localparam int          BIT_TICK    = 6;
    localparam int          BIT_OVF_EN  = 5;
    localparam int          BIT_TICK_EN = 4;
    localparam int          BIT_OVF_ACK = 3;
    localparam int          BIT_TICK_ACK = 2;
    localparam int          BIT_SEL_HI  = 1;
    localparam int          BIT_SEL_LO  = 0;
    localparam logic [1:0]  SEL_RESET   = 2'h3;
    // interrupt status/mask layout
    localparam int          EVT_OVF     = 0;
    localparam int          EVT_TICK    = 1;
    localparam int          EVT_W       = 2;
    // divider chain shape
    localparam int          PRESCALE_W  = 2;
    localparam int          COUNT_W     = 8;
    localparam int          OVF_BITS    = 10;
    localparam int          TICK_BASE   = 14;
    localparam int          CHAIN_W     = 17;
    // stop exit stabilization, in cycles
    localparam int          STAB_SHORT  = 128;
    localparam int          STAB_LONG   = 4064;
    localparam int          STAB_W      = 12;
    typedef enum logic [1:0] {
        MFT_RUN,
        MFT_STOPPED,
        MFT_SETTLE
    } mft_state_t;
endpackage

// File: design/mft_timer.sv
// multi-function timer: divider chain, flags, avalon slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module mft_timer #(
    parameter int STAB_SHORT = mft_pkg::STAB_SHORT,
    parameter int STAB_LONG  = mft_pkg::STAB_LONG
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        stop_req,
    input  wire logic        wake_pin,
    output logic             running,
    output logic             timer_irq,
    output logic             irq
);
    // state
    mft_pkg::mft_state_t                state, next_state;
    logic [mft_pkg::CHAIN_W-1:0]        chain, next_chain;
    logic [mft_pkg::STAB_W-1:0]         stab_cnt, next_stab_cnt;
    logic                               stab_long, next_stab_long;
    logic                               overflow_flag, next_overflow_flag;
    logic                               periodic_tick_flag, next_periodic_tick_flag;
    logic                               overflow_irq_enable, next_overflow_irq_enable;
    logic                               periodic_tick_irq_enable, next_periodic_tick_irq_enable;
    logic [1:0]                         period_sel, next_period_sel;
    logic [mft_pkg::EVT_W-1:0]          istat, next_istat;
    logic [mft_pkg::EVT_W-1:0]          imask, next_imask;
    logic                               wait_q, next_wait_q;
    logic [31:0]                        rdata, next_rdata;
    logic                               timer_irq_q, next_timer_irq_q;
    logic                               irq_q, next_irq_q;
    logic                               wake_s1, wake_s2;
    logic                               running_q, next_running_q;
    // decode and events
    logic                               accept;
    logic                               wr_lane;
    logic                               wr_tcs;
    logic                               ovf_evt;
    logic                               tick_evt;
    logic [mft_pkg::CHAIN_W-1:0]        tick_mask;
    logic [mft_pkg::STAB_W-1:0]         stab_last;
    logic [7:0]                         tcs_view;

    // wake pin synchroniser
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            wake_s1 <= wake_pin;
            wake_s2 <= wake_s1;
        end
    end

    // bus acceptance, events, read view
    always_comb begin
        accept  = (read || write) && !wait_q;
        wr_lane = accept && write && byteenable[0];
        wr_tcs  = wr_lane && (address == mft_pkg::ADDR_TCS);
        // overflow at wrap of prescaler plus 8-bit count
        ovf_evt = (state == mft_pkg::MFT_RUN) && (&chain[mft_pkg::OVF_BITS-1:0]);
        // selected stage: wrap of low 14+sel chain bits
        for (int i = 0; i < mft_pkg::CHAIN_W; i++) begin
            tick_mask[i] = (i < mft_pkg::TICK_BASE + int'(period_sel));
        end
        tick_evt = (state == mft_pkg::MFT_RUN) && (&(chain | ~tick_mask));
        stab_last = stab_long ? mft_pkg::STAB_W'(STAB_LONG - 1) : mft_pkg::STAB_W'(STAB_SHORT - 1);
        // ack bits always read zero
        tcs_view = '0;
        tcs_view[mft_pkg::BIT_OVF]     = overflow_flag;
        tcs_view[mft_pkg::BIT_TICK]    = periodic_tick_flag;
        tcs_view[mft_pkg::BIT_OVF_EN]  = overflow_irq_enable;
        tcs_view[mft_pkg::BIT_TICK_EN] = periodic_tick_irq_enable;
        tcs_view[mft_pkg::BIT_SEL_HI:mft_pkg::BIT_SEL_LO] = period_sel;
    end

    // stop, stabilization and chain sequencing
    always_comb begin
        next_state    = state;
        next_chain    = chain;
        next_stab_cnt = stab_cnt;
        unique case (state)
            mft_pkg::MFT_RUN: begin
                next_chain = chain + 1'b1;
                if (stop_req) begin
                    next_state = mft_pkg::MFT_STOPPED;
                end
            end
            mft_pkg::MFT_STOPPED: begin
                if (wake_s2) begin
                    next_state    = mft_pkg::MFT_SETTLE;
                    next_stab_cnt = '0;
                end
            end
            mft_pkg::MFT_SETTLE: begin
                next_chain    = '0;
                next_stab_cnt = stab_cnt + 1'b1;
                if (stab_cnt == stab_last) begin
                    next_state = mft_pkg::MFT_RUN;
                end
            end
            default: begin
                next_state = mft_pkg::MFT_SETTLE;
            end
        endcase
        // running pin registered from the next state, no output decode
        next_running_q = (next_state == mft_pkg::MFT_RUN);
    end

    // register file next values
    always_comb begin
        next_overflow_flag            = overflow_flag;
        next_periodic_tick_flag       = periodic_tick_flag;
        next_overflow_irq_enable      = overflow_irq_enable;
        next_periodic_tick_irq_enable = periodic_tick_irq_enable;
        next_period_sel               = period_sel;
        next_imask                    = imask;
        next_stab_long                = stab_long;
        next_istat                    = istat;
        if (wr_tcs) begin
            next_overflow_irq_enable      = writedata[mft_pkg::BIT_OVF_EN];
            next_periodic_tick_irq_enable = writedata[mft_pkg::BIT_TICK_EN];
            next_period_sel = writedata[mft_pkg::BIT_SEL_HI:mft_pkg::BIT_SEL_LO];
            // flag bits in writedata are not used
            if (writedata[mft_pkg::BIT_OVF_ACK]) begin
                next_overflow_flag = 1'b0;
            end
            if (writedata[mft_pkg::BIT_TICK_ACK]) begin
                next_periodic_tick_flag = 1'b0;
            end
        end
        // set wins over acknowledge
        if (ovf_evt) begin
            next_overflow_flag = 1'b1;
        end
        if (tick_evt) begin
            next_periodic_tick_flag = 1'b1;
        end
        if (wr_lane && address == mft_pkg::ADDR_IMASK) begin
            next_imask = writedata[mft_pkg::EVT_W-1:0];
        end
        if (wr_lane && address == mft_pkg::ADDR_STAB) begin
            next_stab_long = writedata[0];
        end
        if (wr_lane && address == mft_pkg::ADDR_ISTAT) begin
            next_istat = istat & ~writedata[mft_pkg::EVT_W-1:0];
        end
        next_istat[mft_pkg::EVT_OVF]  = next_istat[mft_pkg::EVT_OVF] | ovf_evt;
        next_istat[mft_pkg::EVT_TICK] = next_istat[mft_pkg::EVT_TICK] | tick_evt;
        // combined timer request
        next_timer_irq_q = (overflow_flag && overflow_irq_enable)
                        || (periodic_tick_flag && periodic_tick_irq_enable);
        next_irq_q = |(istat & imask);
    end

    // avalon handshake: one wait cycle, then accept
    always_comb begin
        next_wait_q = 1'b1;
        next_rdata  = rdata;
        if ((read || write) && wait_q) begin
            next_wait_q = 1'b0;
        end
        if (read && wait_q) begin
            unique case (address)
                mft_pkg::ADDR_TCS:   next_rdata = {24'h0, tcs_view};
                mft_pkg::ADDR_COUNT: next_rdata = {24'h0,
                    chain[mft_pkg::PRESCALE_W +: mft_pkg::COUNT_W]};
                mft_pkg::ADDR_ISTAT: next_rdata = {30'h0, istat};
                mft_pkg::ADDR_IMASK: next_rdata = {30'h0, imask};
                mft_pkg::ADDR_STAB:  next_rdata = {31'h0, stab_long};
                default:             next_rdata = 32'h0;
            endcase
        end
    end

    // registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state                    <= mft_pkg::MFT_SETTLE;
            chain                    <= '0;
            stab_cnt                 <= '0;
            stab_long                <= 1'b0;
            overflow_flag            <= 1'b0;
            periodic_tick_flag       <= 1'b0;
            overflow_irq_enable      <= 1'b0;
            periodic_tick_irq_enable <= 1'b0;
            period_sel               <= mft_pkg::SEL_RESET;
            istat                    <= '0;
            imask                    <= '0;
            wait_q                   <= 1'b1;
            rdata                    <= 32'h0;
            timer_irq_q              <= 1'b0;
            irq_q                    <= 1'b0;
            running_q                <= 1'b0;
        end else begin
            state                    <= next_state;
            chain                    <= next_chain;
            stab_cnt                 <= next_stab_cnt;
            stab_long                <= next_stab_long;
            overflow_flag            <= next_overflow_flag;
            periodic_tick_flag       <= next_periodic_tick_flag;
            overflow_irq_enable      <= next_overflow_irq_enable;
            periodic_tick_irq_enable <= next_periodic_tick_irq_enable;
            period_sel               <= next_period_sel;
            istat                    <= next_istat;
            imask                    <= next_imask;
            wait_q                   <= next_wait_q;
            rdata                    <= next_rdata;
            timer_irq_q              <= next_timer_irq_q;
            irq_q                    <= next_irq_q;
            running_q                <= next_running_q;
        end
    end

    // outputs from flops
    assign readdata    = rdata;
    assign waitrequest = wait_q;
    assign running     = running_q;
    assign timer_irq   = timer_irq_q;
    assign irq         = irq_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // overflow flag: set on wrap, cleared only by a one acknowledge
    AST_OVF_SET: assert property (ovf_evt |=> overflow_flag)
        else $error("overflow flag not set on wrap");
    AST_OVF_ACK: assert property (wr_tcs && writedata[mft_pkg::BIT_OVF_ACK] && !ovf_evt |=> !overflow_flag)
        else $error("overflow ack did not clear");
    AST_OVF_KEEP: assert property (wr_tcs && !writedata[mft_pkg::BIT_OVF_ACK] && overflow_flag
        |=> overflow_flag)
        else $error("zero ack cleared overflow flag");
    AST_FLAG_SRC: assert property ($rose(overflow_flag) |-> $past(ovf_evt))
        else $error("overflow flag set without wrap");
    AST_OVF_ZERO: assert property (ovf_evt |=> chain[mft_pkg::OVF_BITS-1:0] == '0)
        else $error("overflow not at count wrap");

    // tick flag: set on the selected stage, same acknowledge rules
    AST_TICK_SET: assert property (tick_evt |=> periodic_tick_flag)
        else $error("tick flag not set");
    AST_TICK_ACK: assert property (wr_tcs && writedata[mft_pkg::BIT_TICK_ACK] && !tick_evt
        |=> !periodic_tick_flag)
        else $error("tick ack did not clear");
    AST_TICK_KEEP: assert property (wr_tcs && !writedata[mft_pkg::BIT_TICK_ACK] && periodic_tick_flag
        |=> periodic_tick_flag)
        else $error("zero ack cleared tick flag");
    AST_TICK_SRC: assert property ($rose(periodic_tick_flag) |-> $past(tick_evt))
        else $error("tick flag set without stage event");
    AST_TICK_ZERO: assert property (tick_evt |=> (chain & $past(tick_mask)) == '0)
        else $error("tick not at selected stage wrap");

    // timer request follows the enabled causes
    AST_REQ: assert property ((overflow_flag && overflow_irq_enable)
        || (periodic_tick_flag && periodic_tick_irq_enable) |=> timer_irq)
        else $error("timer request missing");
    AST_REQ_OFF: assert property (!overflow_irq_enable && !periodic_tick_irq_enable
        ##1 !overflow_irq_enable && !periodic_tick_irq_enable |-> !timer_irq)
        else $error("request with both enables clear");
    AST_REQ_CLR: assert property (!(overflow_flag && overflow_irq_enable)
        && !(periodic_tick_flag && periodic_tick_irq_enable) |=> !timer_irq)
        else $error("timer request without cause");

    // bus: read view and one wait cycle per request
    AST_ACK_RD0: assert property (!wait_q && read && address == mft_pkg::ADDR_TCS
        |-> readdata[mft_pkg::BIT_OVF_ACK:mft_pkg::BIT_TICK_ACK] == 2'h0)
        else $error("ack bits read nonzero");
    AST_WAIT: assert property ((read || write) && wait_q |=> !waitrequest ##1 waitrequest)
        else $error("bus answer timing wrong");

    // event status and level interrupt
    AST_ISTAT_SET: assert property (ovf_evt |=> istat[mft_pkg::EVT_OVF])
        else $error("overflow status bit not set");
    AST_ISTAT_TICK: assert property (tick_evt |=> istat[mft_pkg::EVT_TICK])
        else $error("tick status bit not set");
    AST_IRQ_SET: assert property ((istat & imask) != '0 |=> irq)
        else $error("interrupt missing for unmasked status");
    AST_IRQ_CLR: assert property ((istat & imask) == '0 |=> !irq)
        else $error("interrupt without unmasked status");

    // stop, settle and restart
    AST_SETTLE: assert property (state == mft_pkg::MFT_SETTLE && stab_cnt == stab_last
        |=> running && chain == '0)
        else $error("settle exit wrong");
    AST_HOLD: assert property (state == mft_pkg::MFT_STOPPED |=> $stable(chain))
        else $error("chain moved while stopped");

    // main scenarios
    COV_OVF: cover property (ovf_evt ##1 wr_tcs && writedata[mft_pkg::BIT_OVF_ACK]);
    COV_TICK: cover property (tick_evt && period_sel == 2'h0);
    COV_WAKE: cover property (state == mft_pkg::MFT_STOPPED ##1 state == mft_pkg::MFT_SETTLE);
    COV_RACE: cover property (wr_tcs && writedata[mft_pkg::BIT_OVF_ACK] && ovf_evt);
    COV_LONG: cover property (state == mft_pkg::MFT_SETTLE && stab_long);
endmodule
`default_nettype wire

// File: tb/testbench.sv
// self-checking bench for the multi-function timer
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk;
    logic        reset;
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        stop_req;
    logic        wake_pin;
    logic        running;
    logic        timer_irq;
    logic        irq;
    int          n_errors;
    int          total_checks;
    int          cyc = 0;
    int          t1;
    int          t2;
    logic [31:0] v;
    logic [31:0] w;

    mft_timer #(.STAB_SHORT(4), .STAB_LONG(8)) u_dut (
        .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .stop_req(stop_req), .wake_pin(wake_pin),
        .running(running), .timer_irq(timer_irq), .irq(irq)
    );

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // cycle count for interval measurement
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        address <= a;
        writedata <= {24'h0, d};
        write <= wr;
        read <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        if (n >= 50) check(32'h0, 32'h1);
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, output logic [31:0] q);
        bus(1'b0, a, 8'h0, q);
    endtask

    // waits for timer_irq to go low, then high; returns the cycle of the rise
    task automatic wait_rise(output int t);
        int n;
        n = 0;
        while (timer_irq !== 1'b0 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        while (timer_irq !== 1'b1 && n < 40000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 40000) check(32'h0, 32'h1);
        t = cyc;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // watchdog: tests take about 66k cycles
    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        close_out();
    end

    initial begin
        reset = 1'b1; address = 5'h0; read = 1'b0; write = 1'b0; writedata = 32'h0;
        byteenable = 4'hf; stop_req = 1'b0; wake_pin = 1'b0;
        n_errors = 0; total_checks = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        // reset values and unmapped address
        rd(mft_pkg::ADDR_TCS, v);   check(v, 32'h03);
        rd(mft_pkg::ADDR_COUNT, v); check(v, 32'h00);
        rd(mft_pkg::ADDR_ISTAT, v); check(v, 32'h00);
        rd(mft_pkg::ADDR_IMASK, v); check(v, 32'h00);
        rd(5'h1c, v);               check(v, 32'h00);
        check({31'h0, timer_irq}, 32'h0);
        $display("test reset done");
        // flag writes ignored, acks read zero, field layout
        wr(mft_pkg::ADDR_TCS, 8'hcc);
        rd(mft_pkg::ADDR_TCS, v);   check(v, 32'h00);
        wr(mft_pkg::ADDR_TCS, 8'h20);
        rd(mft_pkg::ADDR_TCS, v);   check(v, 32'h20);
        // write without the low byte lane is ignored
        byteenable <= 4'he;
        wr(mft_pkg::ADDR_TCS, 8'h13);
        byteenable <= 4'hf;
        rd(mft_pkg::ADDR_TCS, v);   check(v, 32'h20);
        $display("test layout done");
        // overflow flag, enable, acknowledge, period
        wait_rise(t1);
        rd(mft_pkg::ADDR_TCS, v);   check(v, 32'ha0);
        wr(mft_pkg::ADDR_TCS, 8'h20);
        rd(mft_pkg::ADDR_TCS, v);   check(v, 32'ha0);
        wr(mft_pkg::ADDR_TCS, 8'h28);
        rd(mft_pkg::ADDR_TCS, v);   check(v, 32'h20);
        check({31'h0, timer_irq}, 32'h0);
        wait_rise(t2);
        check(t2 - t1, 32'd1024);
        wr(mft_pkg::ADDR_TCS, 8'h00);
        repeat (1100) @(posedge clk);
        check({31'h0, timer_irq}, 32'h0);
        rd(mft_pkg::ADDR_TCS, v);   check(v, 32'h80);
        wr(mft_pkg::ADDR_TCS, 8'h08);
        rd(mft_pkg::ADDR_TCS, v);   check(v, 32'h00);
        $display("test overflow done");
        // periodic tick at the shortest period
        wr(mft_pkg::ADDR_TCS, 8'h10);
        wait_rise(t1);
        rd(mft_pkg::ADDR_TCS, v);   check(v & 32'h7f, 32'h50);
        wr(mft_pkg::ADDR_TCS, 8'h10);
        rd(mft_pkg::ADDR_TCS, v);   check(v & 32'h7f, 32'h50);
        wr(mft_pkg::ADDR_TCS, 8'h14);
        rd(mft_pkg::ADDR_TCS, v);   check(v & 32'h7f, 32'h10);
        wait_rise(t2);
        check(t2 - t1, 32'd16384);
        // next select value doubles the period
        wr(mft_pkg::ADDR_TCS, 8'h15);
        wait_rise(t1);
        check(t1 - t2, 32'd32768);
        $display("test tick done");
        // event status, mask and level interrupt
        wr(mft_pkg::ADDR_TCS, 8'h00);
        rd(mft_pkg::ADDR_ISTAT, v); check(v, 32'h03);
        repeat (3) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        wr(mft_pkg::ADDR_IMASK, 8'h01);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h1);
        wr(mft_pkg::ADDR_ISTAT, 8'h03);
        repeat (2) @(posedge clk);
        check({31'h0, irq}, 32'h0);
        rd(mft_pkg::ADDR_ISTAT, v); check(v & 32'h2, 32'h0);
        $display("test interrupt done");
        // stop freezes the chain, wake restarts it
        stop_req <= 1'b1;
        repeat (3) @(posedge clk);
        stop_req <= 1'b0;
        check({31'h0, running}, 32'h0);
        rd(mft_pkg::ADDR_COUNT, v);
        repeat (20) @(posedge clk);
        rd(mft_pkg::ADDR_COUNT, w); check(w, v);
        wake_pin <= 1'b1;
        t1 = 0;
        while (running !== 1'b1 && t1 < 40) begin
            @(posedge clk);
            t1++;
        end
        wake_pin <= 1'b0;
        check({31'h0, running}, 32'h1);
        // two sync stages, one decode, four settle cycles, one sample
        check(t1, 32'd8);
        rd(mft_pkg::ADDR_COUNT, v); check(v, 32'h00);
        // long stabilization: eight settle cycles
        wr(mft_pkg::ADDR_STAB, 8'h01);
        rd(mft_pkg::ADDR_STAB, v);  check(v, 32'h01);
        stop_req <= 1'b1;
        @(posedge clk);
        stop_req <= 1'b0;
        @(posedge clk);
        check({31'h0, running}, 32'h0);
        wake_pin <= 1'b1;
        t1 = 0;
        while (running !== 1'b1 && t1 < 40) begin
            @(posedge clk);
            t1++;
        end
        wake_pin <= 1'b0;
        check(t1, 32'd12);
        $display("test stop done");
        close_out();
    end
endmodule
`default_nettype wire
